// [hw/spio_port.sv]
// spio_port: serial pcm input/output port with apb register access.
// assumes pins arrive unsynchronised; the link clocks are sampled by pclk
// and must run well below pclk/4.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module spio_port #(
    parameter int DATA_W = 16
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // core-side flags
    output logic out_shift_empty_flag,
    output logic in_buffer_full_flag,
    // serial data
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic out_drive_enable_low,
    // input bit clock and load strobe
    input wire logic in_bit_clock_i,
    output logic in_bit_clock_o,
    output logic in_bit_clock_oe,
    input wire logic in_word_load_strobe_i,
    output logic in_word_load_strobe_o,
    output logic in_word_load_strobe_oe,
    // output bit clock and load strobe
    input wire logic out_bit_clock_i,
    output logic out_bit_clock_o,
    output logic out_bit_clock_oe,
    input wire logic out_word_load_strobe_i,
    output logic out_word_load_strobe_o,
    output logic out_word_load_strobe_oe
);
    import spio_pkg::*;

    if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
        $error("spio_port: DATA_W must be 1 to 16");
    end

    // synchronised pins
    logic din_s;
    logic ibc_s;
    logic iws_s;
    logic obc_s;
    logic ows_s;
    logic dren_n_s;
    logic iws_act_s;
    logic ows_act_s;

    // strobes pass inverted so the zero reset of the flops reads as idle high
    spio_sync #(
        .WIDTH(6)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_i({serial_data_in, in_bit_clock_i, ~in_word_load_strobe_i,
                  out_bit_clock_i, ~out_word_load_strobe_i, out_drive_enable_low}),
        .sync_o({din_s, ibc_s, iws_act_s, obc_s, ows_act_s, dren_n_s})
    );

    assign iws_s = ~iws_act_s;
    assign ows_s = ~ows_act_s;

    // registers
    logic [11:0] ctrl_q;
    logic [15:0] clkdiv_q;
    logic [SPIO_IRQ_W-1:0] irq_stat_q;
    logic [SPIO_IRQ_W-1:0] irq_mask_q;
    logic [15:0] obuf_q;
    logic tx_pend_q;
    logic [15:0] ibuf_q;
    logic txe_q;
    logic rxf_q;

    logic msb_first;
    logic [4:0] word_len;
    logic [4:0] len_req;

    assign msb_first = ctrl_q[SPIO_CTRL_MSB_FIRST];
    assign len_req = 5'(SPIO_WORD_LEN_MAX -
                        {1'b0, ctrl_q[SPIO_CTRL_LEN_LSB +: SPIO_CTRL_LEN_W]});
    // field zero gives 16 bit words, never longer than the data path
    assign word_len = (len_req > 5'(DATA_W)) ? 5'(DATA_W) : len_req;

    // apb decode
    logic acc;
    logic wr;
    logic rd;
    logic mapped;

    assign acc = psel & penable;
    assign wr = acc & pwrite & mapped;
    assign rd = acc & ~pwrite & mapped;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    always_comb begin
        if (paddr == SPIO_REG_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_TXDATA) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_RXDATA) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_IRQ_STAT) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_IRQ_MASK) begin
            mapped = 1'b1;
        end else if (paddr == SPIO_REG_CLKDIV) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    logic wr_txdata;
    logic rd_rxdata;
    assign wr_txdata = wr & (paddr == SPIO_REG_TXDATA);
    assign rd_rxdata = rd & (paddr == SPIO_REG_RXDATA);

    // control, divider and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= SPIO_CTRL_RESET;
            clkdiv_q <= SPIO_CLKDIV_RESET;
            irq_mask_q <= '0;
        end else if (wr) begin
            if (paddr == SPIO_REG_CTRL) begin
                ctrl_q <= pwdata[11:0];
            end else if (paddr == SPIO_REG_CLKDIV) begin
                clkdiv_q <= pwdata[15:0];
            end else if (paddr == SPIO_REG_IRQ_MASK) begin
                irq_mask_q <= pwdata[SPIO_IRQ_W-1:0];
            end
        end
    end

    // active-mode generators
    logic gen_ibc;
    logic gen_iws_n;
    logic gen_obc;
    logic gen_ows_n;

    spio_clkgen u_in_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_q[SPIO_CTRL_IN_CLK_ACT]),
        .half_div(clkdiv_q),
        .len(word_len),
        .bit_clk_o(gen_ibc),
        .load_n_o(gen_iws_n)
    );

    spio_clkgen u_out_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_q[SPIO_CTRL_OUT_CLK_ACT]),
        .half_div(clkdiv_q),
        .len(word_len),
        .bit_clk_o(gen_obc),
        .load_n_o(gen_ows_n)
    );

    // pin directions: drive only in active mode
    assign in_bit_clock_o = gen_ibc;
    assign in_bit_clock_oe = ctrl_q[SPIO_CTRL_IN_CLK_ACT];
    assign in_word_load_strobe_o = gen_iws_n;
    assign in_word_load_strobe_oe = ctrl_q[SPIO_CTRL_IN_LOAD_ACT];
    assign out_bit_clock_o = gen_obc;
    assign out_bit_clock_oe = ctrl_q[SPIO_CTRL_OUT_CLK_ACT];
    assign out_word_load_strobe_o = gen_ows_n;
    assign out_word_load_strobe_oe = ctrl_q[SPIO_CTRL_OUT_LOAD_ACT];

    // effective link levels and their edges
    logic ibc_lvl;
    logic iws_lvl;
    logic obc_lvl;
    logic ows_lvl;
    logic ibc_prev_q;
    logic iws_prev_q;
    logic obc_prev_q;
    logic ows_prev_q;

    assign ibc_lvl = ctrl_q[SPIO_CTRL_IN_CLK_ACT] ? gen_ibc : ibc_s;
    assign iws_lvl = ctrl_q[SPIO_CTRL_IN_LOAD_ACT] ? gen_iws_n : iws_s;
    assign obc_lvl = ctrl_q[SPIO_CTRL_OUT_CLK_ACT] ? gen_obc : obc_s;
    assign ows_lvl = ctrl_q[SPIO_CTRL_OUT_LOAD_ACT] ? gen_ows_n : ows_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ibc_prev_q <= 1'b0;
            iws_prev_q <= 1'b1;
            obc_prev_q <= 1'b0;
            ows_prev_q <= 1'b1;
        end else begin
            ibc_prev_q <= ibc_lvl;
            iws_prev_q <= iws_lvl;
            obc_prev_q <= obc_lvl;
            ows_prev_q <= ows_lvl;
        end
    end

    logic ibc_rise;
    logic iws_fall;
    logic obc_rise;
    logic ows_fall;
    assign ibc_rise = ibc_lvl & ~ibc_prev_q;
    assign iws_fall = ~iws_lvl & iws_prev_q;
    assign obc_rise = obc_lvl & ~obc_prev_q;
    assign ows_fall = ~ows_lvl & ows_prev_q;

    // receiver
    logic rx_busy_q;
    logic [4:0] rx_cnt_q;
    logic [15:0] rx_sr_q;
    logic [15:0] rx_word;
    logic rx_done;

    always_comb begin
        rx_word = rx_sr_q;
        rx_word[spio_bit_pos(msb_first, rx_cnt_q, word_len)] = din_s;
    end

    assign rx_done = rx_busy_q & ibc_rise & (rx_cnt_q + 5'd1 >= word_len);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= 5'd0;
            rx_sr_q <= 16'h0000;
        end else if (iws_fall) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q <= 5'd0;
            rx_sr_q <= 16'h0000;
        end else if (rx_busy_q && ibc_rise) begin
            rx_sr_q <= rx_word;
            rx_cnt_q <= 5'(rx_cnt_q + 5'd1);
            if (rx_done) begin
                rx_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ibuf_q <= 16'h0000;
        end else if (rx_done) begin
            ibuf_q <= rx_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxf_q <= 1'b0;
        end else if (rx_done) begin
            rxf_q <= 1'b1;
        end else if (rd_rxdata) begin
            rxf_q <= 1'b0;
        end
    end

    // transmitter
    logic tx_busy_q;
    logic [4:0] tx_cnt_q;
    logic [15:0] osr_q;
    logic dout_q;
    logic tx_start;
    logic tx_done;

    assign tx_start = ows_fall & tx_pend_q;
    assign tx_done = tx_busy_q & ~ows_fall & obc_rise & (tx_cnt_q >= word_len);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obuf_q <= 16'h0000;
            tx_pend_q <= 1'b0;
        end else if (wr_txdata) begin
            obuf_q <= pwdata[15:0];
            tx_pend_q <= 1'b1;
        end else if (tx_start) begin
            tx_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 5'd0;
            osr_q <= 16'h0000;
            dout_q <= 1'b0;
        end else if (tx_start) begin
            osr_q <= obuf_q;
            tx_busy_q <= 1'b1;
            tx_cnt_q <= 5'd0;
        end else if (tx_busy_q && obc_rise) begin
            if (tx_done) begin
                tx_busy_q <= 1'b0;
            end else begin
                dout_q <= osr_q[spio_bit_pos(msb_first, tx_cnt_q, word_len)];
                tx_cnt_q <= 5'(tx_cnt_q + 5'd1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txe_q <= 1'b1;
        end else if (tx_done) begin
            txe_q <= 1'b1;
        end else if (wr_txdata) begin
            txe_q <= 1'b0;
        end
    end

    assign serial_data_out = dout_q;
    assign serial_data_out_oe = ~dren_n_s;
    assign out_shift_empty_flag = txe_q;
    assign in_buffer_full_flag = rxf_q;

    // interrupt status: set wins over write-one-to-clear
    logic [SPIO_IRQ_W-1:0] irq_set;
    logic [SPIO_IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[SPIO_IRQ_TX_DONE] = tx_done;
        irq_set[SPIO_IRQ_RX_FULL] = rx_done;
        irq_set[SPIO_IRQ_RX_OVERRUN] = rx_done & rxf_q & ~rd_rxdata;
        irq_set[SPIO_IRQ_TX_UNDERRUN] = ows_fall & ~tx_pend_q;
        irq_clr = (wr && paddr == SPIO_REG_IRQ_STAT) ? pwdata[SPIO_IRQ_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // read data, registered in the setup cycle
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        if (paddr == SPIO_REG_CTRL) begin
            rdata[11:0] = ctrl_q;
        end else if (paddr == SPIO_REG_STATUS) begin
            rdata[SPIO_ST_TXE] = txe_q;
            rdata[SPIO_ST_RXF] = rxf_q;
            rdata[SPIO_ST_TX_PEND] = tx_pend_q;
            rdata[SPIO_ST_RX_BUSY] = rx_busy_q;
            rdata[SPIO_ST_TX_BUSY] = tx_busy_q;
        end else if (paddr == SPIO_REG_TXDATA) begin
            rdata[15:0] = obuf_q;
        end else if (paddr == SPIO_REG_RXDATA) begin
            rdata[15:0] = ibuf_q;
        end else if (paddr == SPIO_REG_IRQ_STAT) begin
            rdata[SPIO_IRQ_W-1:0] = irq_stat_q;
        end else if (paddr == SPIO_REG_IRQ_MASK) begin
            rdata[SPIO_IRQ_W-1:0] = irq_mask_q;
        end else if (paddr == SPIO_REG_CLKDIV) begin
            rdata[15:0] = clkdiv_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rdata;
        end
    end

endmodule : spio_port

// [common/spio_pkg.sv]
// spio_pkg: register map, field positions, reset values and helpers
// for the serial pcm port; shared by every file of the port.
package spio_pkg;

    // apb register byte offsets
    localparam logic [7:0] SPIO_REG_CTRL = 8'h00;
    localparam logic [7:0] SPIO_REG_STATUS = 8'h04;
    localparam logic [7:0] SPIO_REG_TXDATA = 8'h08;
    localparam logic [7:0] SPIO_REG_RXDATA = 8'h0c;
    localparam logic [7:0] SPIO_REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] SPIO_REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] SPIO_REG_CLKDIV = 8'h18;

    // serial control register fields
    localparam int SPIO_CTRL_MSB_FIRST = 0;
    localparam int SPIO_CTRL_IN_LOAD_ACT = 1;
    localparam int SPIO_CTRL_OUT_LOAD_ACT = 2;
    localparam int SPIO_CTRL_IN_CLK_ACT = 3;
    localparam int SPIO_CTRL_OUT_CLK_ACT = 4;
    localparam int SPIO_CTRL_LEN_LSB = 8;
    localparam int SPIO_CTRL_LEN_W = 4;
    localparam logic [11:0] SPIO_CTRL_RESET = 12'h000;

    // status register bits
    localparam int SPIO_ST_TXE = 0;
    localparam int SPIO_ST_RXF = 1;
    localparam int SPIO_ST_TX_PEND = 2;
    localparam int SPIO_ST_RX_BUSY = 3;
    localparam int SPIO_ST_TX_BUSY = 4;

    // interrupt status and mask bits
    localparam int SPIO_IRQ_W = 4;
    localparam int SPIO_IRQ_TX_DONE = 0;
    localparam int SPIO_IRQ_RX_FULL = 1;
    localparam int SPIO_IRQ_RX_OVERRUN = 2;
    localparam int SPIO_IRQ_TX_UNDERRUN = 3;

    // word length and active bit clock half period in pclk cycles
    localparam logic [4:0] SPIO_WORD_LEN_MAX = 5'd16;
    localparam logic [15:0] SPIO_CLKDIV_RESET = 16'h0008;
    localparam int SPIO_SYNC_STAGES = 2;

    // position of serial bit number cnt within a word of len bits
    function automatic logic [3:0] spio_bit_pos(input logic msb_first,
                                                input logic [4:0] cnt,
                                                input logic [4:0] len);
        logic [4:0] pos;
        pos = msb_first ? 5'(len - 5'd1 - cnt) : cnt;
        return pos[3:0];
    endfunction : spio_bit_pos

endpackage : spio_pkg

// [hw/spio_sync.sv]
// spio_sync: two flip-flop synchroniser for a bundle of pins.
// assumes each bit is an independent level from outside the pclk domain.
`timescale 1ns/1ps
module spio_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    import spio_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : spio_sync

// [hw/spio_clkgen.sv]
// spio_clkgen: active-mode bit clock and word load strobe generator.
// assumes half_div and len are quasi static while run is high.
`timescale 1ns/1ps
module spio_clkgen (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [15:0] half_div,
    input wire logic [4:0] len,
    // generated link levels
    output logic bit_clk_o,
    output logic load_n_o
);
    import spio_pkg::*;

    logic [15:0] hcnt_q;
    logic [4:0] bcnt_q;
    logic clk_q;
    logic load_n_q;
    logic half_end;

    // a divider of zero behaves as one
    assign half_end = (hcnt_q + 16'd1 >= half_div);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt_q <= 16'h0000;
            bcnt_q <= 5'd0;
            clk_q <= 1'b0;
            load_n_q <= 1'b1;
        end else if (!run) begin
            hcnt_q <= 16'h0000;
            bcnt_q <= 5'd0;
            clk_q <= 1'b0;
            load_n_q <= 1'b1;
        end else if (half_end) begin
            hcnt_q <= 16'h0000;
            clk_q <= ~clk_q;
            if (clk_q) begin
                // strobe falls at the falling clock edge before bit 0
                load_n_q <= (bcnt_q != 5'd0);
                bcnt_q <= (bcnt_q + 5'd1 >= len) ? 5'd0 : 5'(bcnt_q + 5'd1);
            end
        end else begin
            hcnt_q <= 16'(hcnt_q + 16'd1);
        end
    end

    assign bit_clk_o = clk_q;
    assign load_n_o = load_n_q;

endmodule : spio_clkgen

// [bench/spio_port_props.sv]
// spio_port_props: concurrent checks on the serial pcm port pins.
// assumes link inputs carry the resolved pin levels; bound to spio_port.
`timescale 1ns/1ps
module spio_port_props
    import spio_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // flags
    input wire logic out_shift_empty_flag,
    input wire logic in_buffer_full_flag,
    // serial pins
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic out_drive_enable_low,
    input wire logic in_bit_clock_i,
    input wire logic in_bit_clock_oe,
    input wire logic in_word_load_strobe_oe,
    input wire logic out_bit_clock_i,
    input wire logic out_bit_clock_oe,
    input wire logic out_word_load_strobe_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;

    a_reset_flags: assert property ($rose(presetn) |-> out_shift_empty_flag
        && !in_buffer_full_flag) else $error("flags wrong after reset");
    a_reset_passive: assert property ($rose(presetn) |-> !in_bit_clock_oe
        && !out_bit_clock_oe && !in_word_load_strobe_oe && !out_word_load_strobe_oe)
        else $error("port not passive after reset");
    a_tx_write_clear: assert property (acc && pwrite && paddr == SPIO_REG_TXDATA
        |=> !out_shift_empty_flag) else $error("empty flag kept after word write");
    a_rx_read_clear: assert property (acc && !pwrite && paddr == SPIO_REG_RXDATA
        |=> !in_buffer_full_flag) else $error("full flag kept after read");
    a_empty_on_rise: assert property ($rose(out_shift_empty_flag)
        |-> out_bit_clock_i) else $error("empty flag set away from clock rise");
    a_full_on_rise: assert property ($rose(in_buffer_full_flag)
        |-> in_bit_clock_i) else $error("full flag set away from clock rise");
    a_dout_quiet_low: assert property ((!out_bit_clock_i)[*5]
        |-> $stable(serial_data_out)) else $error("data out moved while clock low");
    a_ctrl_dirs: assert property (acc && pwrite
        && paddr == SPIO_REG_CTRL |=>
        {out_bit_clock_oe, in_bit_clock_oe, out_word_load_strobe_oe, in_word_load_strobe_oe}
        == {$past(pwdata[SPIO_CTRL_OUT_CLK_ACT]), $past(pwdata[SPIO_CTRL_IN_CLK_ACT]),
        $past(pwdata[SPIO_CTRL_OUT_LOAD_ACT]), $past(pwdata[SPIO_CTRL_IN_LOAD_ACT])})
        else $error("pin directions differ from control");
    a_dout_enable: assert property ($stable(out_drive_enable_low)[*3]
        |-> serial_data_out_oe == !out_drive_enable_low) else $error("data out enable wrong");
    a_unmapped_err: assert property (acc && paddr > 8'h1b |-> pslverr)
        else $error("no error on unmapped access");
endmodule : spio_port_props

bind spio_port spio_port_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .out_shift_empty_flag(out_shift_empty_flag), .in_buffer_full_flag(in_buffer_full_flag),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .out_drive_enable_low(out_drive_enable_low), .in_bit_clock_i(in_bit_clock_i),
    .in_bit_clock_oe(in_bit_clock_oe), .in_word_load_strobe_oe(in_word_load_strobe_oe),
    .out_bit_clock_i(out_bit_clock_i), .out_bit_clock_oe(out_bit_clock_oe),
    .out_word_load_strobe_oe(out_word_load_strobe_oe));

// [bench/spio_codec_model.sv]
// spio_codec_model: far-end serial codec; passive clocks, data source and sink.
// assumes *_w inputs are the resolved pin levels seen on the link.
`timescale 1ns/1ps
module spio_codec_model (
    // levels driven when the port is passive
    output logic in_ck,
    output logic in_ld,
    output logic data_in,
    output logic out_ck,
    output logic out_ld,
    // resolved pins
    input wire logic in_ck_w,
    input wire logic in_ld_w,
    input wire logic out_ck_w,
    input wire logic out_ld_w,
    input wire logic dout_w
);
    logic [15:0] tx_bits;
    logic [15:0] rx_bits;
    int nbits;
    int icnt;
    int ocnt;
    initial begin
        {in_ck, out_ck, data_in} = 3'h0;
        {in_ld, out_ld} = 2'h3;
        tx_bits = 16'h0;
        rx_bits = 16'h0;
        nbits = 16;
        icnt = 17;
        ocnt = 17;
    end
    // data source: first bit at strobe fall, next bits at clock falls
    always @(negedge in_ld_w) begin
        icnt = 0;
        data_in = tx_bits[0];
    end
    always @(posedge in_ck_w) if (icnt <= nbits) icnt++;
    always @(negedge in_ck_w) begin
        if (icnt >= 1 && icnt < nbits) data_in = tx_bits[icnt];
        else if (icnt >= nbits) data_in = ~data_in;
    end
    // data sink: bit k-1 is settled at the fall after clock rise k
    // cleared late so a clock fall at the same instant still captures its bit
    always @(negedge out_ld_w) ocnt <= 0;
    always @(posedge out_ck_w) if (ocnt <= nbits) ocnt++;
    always @(negedge out_ck_w) if (ocnt >= 1 && ocnt <= nbits) rx_bits[ocnt-1] = dout_w;
    // one passive frame: dir 0 input link, dir 1 output link
    task frame(input logic dir);
        #13.3;
        if (dir) out_ld = 0; else in_ld = 0;
        #32;
        for (int k = 0; k <= nbits; k++) begin
            if (dir) out_ck = 1; else in_ck = 1;
            #32;
            {in_ld, out_ld} = 2'h3;
            if (dir) out_ck = 0; else in_ck = 0;
            #32;
        end
    endtask : frame
endmodule : spio_codec_model

// [bench/tb.sv]
// tb: self-checking bench for spio_port with the codec model on the link.
// assumes apb zero or more wait states; link clock period 64 ns.
`timescale 1ns/1ps
module tb;
    import spio_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic txe, rxf, sdi, sdo, sdo_oe, dren_n;
    logic ibc_o, ibc_oe, iws_o, iws_oe, obc_o, obc_oe, ows_o, ows_oe;
    logic m_ibc, m_iws, m_obc, m_ows;
    wire logic ibc_w, iws_w, obc_w, ows_w, dout_w;
    int failures, num_checks;
    assign ibc_w = ibc_oe ? ibc_o : m_ibc;
    assign iws_w = iws_oe ? iws_o : m_iws;
    assign obc_w = obc_oe ? obc_o : m_obc;
    assign ows_w = ows_oe ? ows_o : m_ows;
    assign dout_w = sdo_oe ? sdo : 1'bz;

    spio_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .out_shift_empty_flag(txe), .in_buffer_full_flag(rxf),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
        .out_drive_enable_low(dren_n), .in_bit_clock_i(ibc_w), .in_bit_clock_o(ibc_o),
        .in_bit_clock_oe(ibc_oe), .in_word_load_strobe_i(iws_w), .in_word_load_strobe_o(iws_o),
        .in_word_load_strobe_oe(iws_oe), .out_bit_clock_i(obc_w), .out_bit_clock_o(obc_o),
        .out_bit_clock_oe(obc_oe), .out_word_load_strobe_i(ows_w),
        .out_word_load_strobe_o(ows_o), .out_word_load_strobe_oe(ows_oe));
    spio_codec_model codec (.in_ck(m_ibc), .in_ld(m_iws), .data_in(sdi), .out_ck(m_obc),
        .out_ld(m_ows), .in_ck_w(ibc_w), .in_ld_w(iws_w), .out_ck_w(obc_w), .out_ld_w(ows_w),
        .dout_w(dout_w));

    always #2 pclk = ~pclk;

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 50) begin failures++; wrap_up; end
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d, rd);
    endtask : wr
    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0, rd);
        chk(n, e, rd);
    endtask : rdc
    task wait_sig(input int sel);
        for (int n = 0; n < 4000; n++) begin
            @(posedge pclk);
            if ((sel == 0 ? rxf : txe) === 1'b1) return;
        end
        failures++;
        wrap_up;
    endtask : wait_sig
    function automatic logic [15:0] order(input logic [15:0] d, input logic m, input int len);
        logic [15:0] r;
        r = 16'h0;
        for (int i = 0; i < len; i++) r[i] = m ? d[len-1-i] : d[i];
        return r;
    endfunction : order

    task t_reset;
        chk("txe", 1, txe);
        chk("rxf", 0, rxf);
        rdc("ctrl", SPIO_REG_CTRL, 32'h0);
        rdc("status", SPIO_REG_STATUS, 32'h1);
        rdc("clkdiv", SPIO_REG_CLKDIV, 32'h8);
        rdc("unmapped", 8'h20, 32'h0);
        chk("slverr", 1, err);
        wr(SPIO_REG_IRQ_MASK, 32'h2);
    endtask : t_reset
    task t_rx(input logic m, input logic [3:0] code, input logic [15:0] d);
        codec.nbits = 16 - code;
        codec.tx_bits = order(d, m, 16 - code);
        wr(SPIO_REG_CTRL, {20'h0, code, 7'h0, m});
        codec.frame(0);
        wait_sig(0);
        rdc("rxdata", SPIO_REG_RXDATA, {16'h0, d});
        chk("rxf", 0, rxf);
        chk("irq", 1, irq);
        wr(SPIO_REG_IRQ_STAT, 32'h2);
        chk("irq", 0, irq);
    endtask : t_rx
    task t_tx(input logic m, input logic [3:0] code, input logic [15:0] d);
        codec.nbits = 16 - code;
        codec.rx_bits = 16'h0;
        wr(SPIO_REG_CTRL, {20'h0, code, 7'h0, m});
        wr(SPIO_REG_TXDATA, {16'h0, d});
        chk("txe", 0, txe);
        rdc("status", SPIO_REG_STATUS, 32'h4);
        codec.frame(1);
        wait_sig(1);
        chk("txbits", order(d, m, 16 - code), codec.rx_bits);
        chk("irq", 0, irq);
        rdc("irqstat", SPIO_REG_IRQ_STAT, 32'h1);
        wr(SPIO_REG_IRQ_STAT, 32'h1);
    endtask : t_tx
    task t_out_drive_enable_low;
        dren_n <= 1;
        repeat (4) @(posedge pclk);
        chk("dout_oe", 0, sdo_oe);
        chk("dout", {31'h0, 1'bz}, dout_w);
        dren_n <= 0;
        repeat (4) @(posedge pclk);
        chk("dout_oe", 1, sdo_oe);
    endtask : t_out_drive_enable_low
    task t_act_tx;
        codec.nbits = 16;
        codec.rx_bits = 16'h0;
        wr(SPIO_REG_CTRL, 32'h0);
        wr(SPIO_REG_TXDATA, 32'h93b6);
        wr(SPIO_REG_CTRL, 32'h14);
        chk("obc_oe", 1, obc_oe);
        chk("ows_oe", 1, ows_oe);
        wait_sig(1);
        chk("txbits", 32'h93b6, codec.rx_bits);
        wr(SPIO_REG_CTRL, 32'h0);
    endtask : t_act_tx
    task t_act_rx;
        codec.nbits = 16;
        codec.tx_bits = 16'h6d91;
        wr(SPIO_REG_CTRL, 32'h0a);
        chk("ibc_oe", 1, ibc_oe);
        chk("iws_oe", 1, iws_oe);
        wait_sig(0);
        rdc("rxdata", SPIO_REG_RXDATA, 32'h6d91);
        wr(SPIO_REG_CTRL, 32'h0);
    endtask : t_act_rx

    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, dren_n} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        failures = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        t_rx(0, 4'h0, 16'ha5c3);
        t_rx(1, 4'h0, 16'h1e77);
        t_rx(1, 4'h4, 16'h0b2d);
        t_tx(0, 4'h0, 16'hc35a);
        t_tx(1, 4'h4, 16'h0e61);
        t_out_drive_enable_low;
        t_act_tx;
        t_act_rx;
        wrap_up;
    end
endmodule : tb
